// ==== src/clk_ctrl_pkg.sv ====
// Constants for the audio clock control slave: register layout, reset value,
// strap codes, address table, decoded rates and link-side state names.
// Assumes the strap pins reach the block already resolved to LOW/HIGH/OPEN.
package clk_ctrl_pkg;

  // ----------------------------------------
  // Control register layout
  // ----------------------------------------
  localparam int CTRL_W = 8;
  localparam logic [7:0] CTRL_RESET = 8'he1;
  localparam int MCLK_EN_BIT = 7;
  localparam int AUDIO_B_EN_BIT = 6;
  localparam int AUDIO_A_EN_BIT = 5;
  localparam int RATE_DOUBLE_BIT = 4;
  localparam int SCALE_LSB = 2;
  localparam int BASE_LSB = 0;

  // ----------------------------------------
  // Decoded selections
  // ----------------------------------------
  localparam logic [9:0] SCALE_256 = 10'h100;
  localparam logic [9:0] SCALE_384 = 10'h180;
  localparam logic [9:0] SCALE_768 = 10'h300;
  localparam logic [9:0] SCALE_RSVD = 10'h000;
  localparam logic [16:0] FS_12K = 17'h02ee0;
  localparam logic [16:0] FS_32K = 17'h07d00;
  localparam logic [16:0] FS_44K1 = 17'h0ac44;
  localparam logic [16:0] FS_48K = 17'h0bb80;

  // ----------------------------------------
  // Address straps
  // ----------------------------------------
  localparam int STRAP_W = 2;
  localparam logic [1:0] STRAP_LOW = 2'h0;
  localparam logic [1:0] STRAP_HIGH = 2'h1;
  localparam logic [1:0] STRAP_OPEN = 2'h2;
  localparam logic [6:0] ADDR_OO = 7'h60;
  localparam logic [6:0] ADDR_LO = 7'h63;
  localparam logic [6:0] ADDR_HO = 7'h62;
  localparam logic [6:0] ADDR_OL = 7'h64;
  localparam logic [6:0] ADDR_LL = 7'h68;
  localparam logic [6:0] ADDR_HL = 7'h70;
  localparam logic [6:0] ADDR_OH = 7'h71;
  localparam logic [6:0] ADDR_LH = 7'h72;
  localparam logic [6:0] ADDR_HH = 7'h74;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  // ----------------------------------------
  // Link side
  // ----------------------------------------
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK_A,
    ST_WR,
    ST_ACK_D,
    ST_RD,
    ST_RD_ACK,
    ST_IGNORE
  } link_state_t;

endpackage : clk_ctrl_pkg

// ==== src/audio_clock_ctrl_i2c_slave.sv ====
// Two-wire slave holding the single control byte of an audio clock generator,
// plus the decoded clock selection in the system clock domain.
// Assumes ref_clk_i runs well above SCL, and straps are stable at reset.
//
// Functional notes
// - Bit 6 enables second audio clock, bit 5 the first one.
// - Bit 4 zero gives standard rate, one gives doubled rate.
// - Bits 3:2 select 256, 384, 768; code 11 reserved.
// - Bits 1:0 select 12, 32, 44.1 or 48 kHz.
// - Base 12 kHz with doubling set still yields 12 kHz.
// - SDA only pulled low by us; SCL is never driven.
// - Both lines stay released and high while bus idle.
// - SDA rising while SCL high ends the transfer, bus free.
// - START or STOP mid-transaction aborts it at once.
// - One bit per SCL pulse; nine bits per byte including ack.
// - Seven address bits, then direction bit: low write, high read.
// - Receiver drives ack: low acknowledge, high not-acknowledge.
// - Each further written byte overwrites the control register.
// - Reads keep returning register contents on extra clocks.
// - Bit 7 enables master clock output; disabled means held low.
// - One 8-bit register, no sub-address byte.
// - Straps sampled after reset latch one of nine addresses.
// - Reset value gives both audio clocks 256 times 32 kHz.
module audio_clock_ctrl_i2c_slave
  import clk_ctrl_pkg::*;
(
  input wire logic mclk_i, // System clock
  input wire logic nrst_i, // Async reset, active low
  input wire logic ref_clk_i, // Link-side clock
  input wire logic scl_i, // Bus clock pin level
  input wire logic sda_i, // Bus data pin level
  input wire logic [clk_ctrl_pkg::STRAP_W-1:0] addr_strap_a_i, // Strap A code
  input wire logic [clk_ctrl_pkg::STRAP_W-1:0] addr_strap_b_i, // Strap B code
  output logic sda_o, // Data pin drive value
  output logic sda_oe_o, // Data pin pull-low enable
  output logic master_clock_en_o, // Master clock enable
  output logic audio_clock_a_en_o, // First audio clock enable
  output logic audio_clock_b_en_o, // Second audio clock enable
  output logic rate_double_o, // Doubled rate selected
  output logic [1:0] scale_sel_o, // Raw scaling code
  output logic [1:0] base_rate_o, // Raw base rate code
  output logic [9:0] scale_factor_o, // Scaling factor, zero if reserved
  output logic [16:0] fs_hz_o, // Sampling frequency in Hz
  output logic [clk_ctrl_pkg::CTRL_W-1:0] ctrl_o // Applied control byte
);
  import clk_ctrl_pkg::*;

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic [6:0] strap_addr(input logic [1:0] a, input logic [1:0] b);
    logic [6:0] r;
    if (b == STRAP_OPEN) begin
      r = (a == STRAP_LOW) ? ADDR_LO : (a == STRAP_HIGH) ? ADDR_HO : ADDR_OO;
    end else if (b == STRAP_LOW) begin
      r = (a == STRAP_LOW) ? ADDR_LL : (a == STRAP_HIGH) ? ADDR_HL : ADDR_OL;
    end else begin
      r = (a == STRAP_LOW) ? ADDR_LH : (a == STRAP_HIGH) ? ADDR_HH : ADDR_OH;
    end
    return r;
  endfunction : strap_addr

  function automatic logic [9:0] scale_of(input logic [1:0] s);
    logic [9:0] r;
    case (s)
      2'h0: r = SCALE_256;
      2'h1: r = SCALE_384;
      2'h2: r = SCALE_768;
      default: r = SCALE_RSVD;
    endcase
    return r;
  endfunction : scale_of

  function automatic logic [16:0] fs_of(input logic [1:0] b, input logic dbl);
    logic [16:0] r;
    case (b)
      2'h1: r = FS_32K;
      2'h2: r = FS_44K1;
      2'h3: r = FS_48K;
      default: r = FS_12K;
    endcase
    // Doubling does not apply to the 12 kHz base
    if (dbl && b != 2'h0) begin
      r = {r[15:0], 1'b0};
    end
    return r;
  endfunction : fs_of

  // ----------------------------------------
  // Link side: pin synchronisers and filter
  // ----------------------------------------
  logic [2:0] scl_s_r;
  logic [2:0] sda_s_r;
  logic scl_f_r, scl_p_r, sda_f_r, sda_p_r;

  // Three stages; a level counts once stages two and three agree
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_s_r <= 3'h7;
      sda_s_r <= 3'h7;
      scl_f_r <= 1'b1;
      scl_p_r <= 1'b1;
      sda_f_r <= 1'b1;
      sda_p_r <= 1'b1;
    end else begin
      scl_s_r <= {scl_s_r[1:0], scl_i};
      sda_s_r <= {sda_s_r[1:0], sda_i};
      if (scl_s_r[1] == scl_s_r[2]) begin
        scl_f_r <= scl_s_r[2];
      end
      if (sda_s_r[1] == sda_s_r[2]) begin
        sda_f_r <= sda_s_r[2];
      end
      scl_p_r <= scl_f_r;
      sda_p_r <= sda_f_r;
    end
  end

  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise = scl_f_r & ~scl_p_r;
  assign scl_fall = ~scl_f_r & scl_p_r;
  assign start_det = scl_f_r & scl_p_r & sda_p_r & ~sda_f_r;
  assign stop_det = scl_f_r & scl_p_r & ~sda_p_r & sda_f_r;

  // ----------------------------------------
  // Link side: address strap capture
  // ----------------------------------------
  logic [1:0] sa_a_s_r [3];
  logic [1:0] sa_b_s_r [3];
  logic [1:0] strap_cnt_r, strap_cnt_nxt;
  logic [6:0] own_addr_r, own_addr_nxt;
  logic addr_ok_r, addr_ok_nxt;

  // Straps are caught by clocked logic after release, never by the reset
  always_comb begin
    strap_cnt_nxt = strap_cnt_r;
    own_addr_nxt = own_addr_r;
    addr_ok_nxt = addr_ok_r;
    if (!addr_ok_r) begin
      if (strap_cnt_r == STRAP_SETTLE) begin
        own_addr_nxt = strap_addr(sa_a_s_r[2], sa_b_s_r[2]);
        addr_ok_nxt = 1'b1;
      end else begin
        strap_cnt_nxt = strap_cnt_r + 2'h1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sa_a_s_r <= '{default: STRAP_OPEN};
      sa_b_s_r <= '{default: STRAP_OPEN};
      strap_cnt_r <= 2'h0;
      own_addr_r <= ADDR_OO;
      addr_ok_r <= 1'b0;
    end else begin
      sa_a_s_r <= '{addr_strap_a_i, sa_a_s_r[0], sa_a_s_r[1]};
      sa_b_s_r <= '{addr_strap_b_i, sa_b_s_r[0], sa_b_s_r[1]};
      strap_cnt_r <= strap_cnt_nxt;
      own_addr_r <= own_addr_nxt;
      addr_ok_r <= addr_ok_nxt;
    end
  end

  // ----------------------------------------
  // Link side: transaction engine
  // ----------------------------------------
  link_state_t st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [7:0] ctrl_r, ctrl_nxt;
  logic tgl_r, tgl_nxt;
  logic low_r, low_nxt;
  logic rw_r, rw_nxt;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    ctrl_nxt = ctrl_r;
    tgl_nxt = tgl_r;
    low_nxt = low_r;
    rw_nxt = rw_r;
    if (start_det) begin
      st_nxt = ST_ADDR;
      cnt_nxt = 4'h0;
      low_nxt = 1'b0;
    end else if (stop_det) begin
      st_nxt = ST_IDLE;
      low_nxt = 1'b0;
    end else begin
      case (st_r)
        ST_ADDR, ST_WR: begin
          if (scl_rise) begin
            sh_nxt = {sh_r[6:0], sda_f_r};
            cnt_nxt = cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == BITS_PER_BYTE) begin
            cnt_nxt = 4'h0;
            if (st_r == ST_WR) begin
              low_nxt = 1'b1;
              st_nxt = ST_ACK_D;
            end else if (addr_ok_r && sh_r[7:1] == own_addr_r) begin
              low_nxt = 1'b1;
              rw_nxt = sh_r[0];
              st_nxt = ST_ACK_A;
            end else begin
              st_nxt = ST_IGNORE;
            end
          end
        end
        ST_ACK_A: begin
          if (scl_fall) begin
            if (rw_r) begin
              sh_nxt = {ctrl_r[6:0], 1'b0};
              low_nxt = ~ctrl_r[7];
              cnt_nxt = 4'h1;
              st_nxt = ST_RD;
            end else begin
              low_nxt = 1'b0;
              st_nxt = ST_WR;
            end
          end
        end
        ST_ACK_D: begin
          // Master samples the ack on this rise, so the byte is now accepted
          if (scl_rise) begin
            ctrl_nxt = sh_r;
            tgl_nxt = ~tgl_r;
          end else if (scl_fall) begin
            low_nxt = 1'b0;
            st_nxt = ST_WR;
          end
        end
        ST_RD: begin
          if (scl_fall) begin
            if (cnt_r == BITS_PER_BYTE) begin
              low_nxt = 1'b0;
              st_nxt = ST_RD_ACK;
            end else begin
              low_nxt = ~sh_r[7];
              sh_nxt = {sh_r[6:0], 1'b0};
              cnt_nxt = cnt_r + 4'h1;
            end
          end
        end
        ST_RD_ACK: begin
          // Ack from master: resend the byte; not-ack: let go for the STOP
          if (scl_fall) begin
            if (!sda_f_r) begin
              sh_nxt = {ctrl_r[6:0], 1'b0};
              low_nxt = ~ctrl_r[7];
              cnt_nxt = 4'h1;
              st_nxt = ST_RD;
            end else begin
              st_nxt = ST_IGNORE;
            end
          end
        end
        default: begin
          low_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= ST_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      ctrl_r <= CTRL_RESET;
      tgl_r <= 1'b0;
      low_r <= 1'b0;
      rw_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      ctrl_r <= ctrl_nxt;
      tgl_r <= tgl_nxt;
      low_r <= low_nxt;
      rw_r <= rw_nxt;
    end
  end

  // Open drain: value fixed low, only the enable moves; SCL has no driver
  assign sda_o = 1'b0;
  assign sda_oe_o = low_r;

  // ----------------------------------------
  // System side: word crossing and decode
  // ----------------------------------------
  logic [1:0] tgl_s_r;
  logic tgl_p_r;
  logic [7:0] ctrl_m_r, ctrl_m_nxt;
  logic [9:0] scale_r, scale_nxt;
  logic [16:0] fs_r, fs_nxt;

  // ctrl_r holds still for many link cycles after each toggle
  always_comb begin
    ctrl_m_nxt = ctrl_m_r;
    if (tgl_s_r[1] != tgl_p_r) begin
      ctrl_m_nxt = ctrl_r;
    end
    scale_nxt = scale_of(ctrl_m_nxt[SCALE_LSB +: 2]);
    fs_nxt = fs_of(ctrl_m_nxt[BASE_LSB +: 2], ctrl_m_nxt[RATE_DOUBLE_BIT]);
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tgl_s_r <= 2'h0;
      tgl_p_r <= 1'b0;
      ctrl_m_r <= CTRL_RESET;
      scale_r <= SCALE_256;
      fs_r <= FS_32K;
    end else begin
      tgl_s_r <= {tgl_s_r[0], tgl_r};
      tgl_p_r <= tgl_s_r[1];
      ctrl_m_r <= ctrl_m_nxt;
      scale_r <= scale_nxt;
      fs_r <= fs_nxt;
    end
  end

  assign master_clock_en_o = ctrl_m_r[MCLK_EN_BIT];
  assign audio_clock_b_en_o = ctrl_m_r[AUDIO_B_EN_BIT];
  assign audio_clock_a_en_o = ctrl_m_r[AUDIO_A_EN_BIT];
  assign rate_double_o = ctrl_m_r[RATE_DOUBLE_BIT];
  assign scale_sel_o = ctrl_m_r[SCALE_LSB +: 2];
  assign base_rate_o = ctrl_m_r[BASE_LSB +: 2];
  assign scale_factor_o = scale_r;
  assign fs_hz_o = fs_r;
  assign ctrl_o = ctrl_m_r;
endmodule : audio_clock_ctrl_i2c_slave

// ==== verification/clk_ctrl_props.sv ====
// Concurrent checks on the ports of the audio clock control slave.
// Bound to the slave; both clock domains share the one reset.
module clk_ctrl_props
  import clk_ctrl_pkg::*;
(
  input wire logic mclk_i, // System clock
  input wire logic nrst_i, // Reset, active low
  input wire logic ref_clk_i, // Link clock
  input wire logic scl_i, // Bus clock
  input wire logic sda_i, // Bus data
  input wire logic sda_o, // Data drive value
  input wire logic sda_oe_o, // Pull-low enable
  input wire logic master_clock_en_o, // Master clock on
  input wire logic audio_clock_a_en_o, // Clock A on
  input wire logic audio_clock_b_en_o, // Clock B on
  input wire logic rate_double_o, // Doubled rate
  input wire logic [1:0] scale_sel_o, // Scale code
  input wire logic [1:0] base_rate_o, // Base code
  input wire logic [9:0] scale_factor_o, // Scale factor
  input wire logic [16:0] fs_hz_o, // Sample rate
  input wire logic [clk_ctrl_pkg::CTRL_W-1:0] ctrl_o // Control byte
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Link side
  // ----------------------------------------
  property p_sda_val;
    @(posedge ref_clk_i) disable iff (!nrst_i) sda_oe_o |-> sda_o == 1'b0;
  endproperty
  a_sda_val: assert property (p_sda_val) else $error("sda drive not low");
  // Drive may only begin while the master holds SCL low
  property p_oe_scl_low;
    @(posedge ref_clk_i) disable iff (!nrst_i) $rose(sda_oe_o) |-> !scl_i;
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low) else $error("sda drive with scl high");
  property p_stop_rel;
    @(posedge ref_clk_i) disable iff (!nrst_i) scl_i && $rose(sda_i) |-> ##[1:8] !sda_oe_o;
  endproperty
  a_stop_rel: assert property (p_stop_rel) else $error("sda held after stop");
  // ----------------------------------------
  // Control outputs
  // ----------------------------------------
  property p_en;
    @(posedge mclk_i) disable iff (!nrst_i)
      {master_clock_en_o, audio_clock_b_en_o, audio_clock_a_en_o} == ctrl_o[7:5];
  endproperty
  a_en: assert property (p_en) else $error("enables differ from control");
  property p_rate;
    @(posedge mclk_i) disable iff (!nrst_i)
      {rate_double_o, scale_sel_o, base_rate_o} == ctrl_o[4:0];
  endproperty
  a_rate: assert property (p_rate) else $error("rate fields differ");
  property p_scale;
    @(posedge mclk_i) disable iff (!nrst_i) scale_factor_o == (ctrl_o[3] ?
      (ctrl_o[2] ? SCALE_RSVD : SCALE_768) : (ctrl_o[2] ? SCALE_384 : SCALE_256));
  endproperty
  a_scale: assert property (p_scale) else $error("scale decode wrong");
  property p_fs12;
    @(posedge mclk_i) disable iff (!nrst_i) ctrl_o[1:0] == 2'h0 |-> fs_hz_o == FS_12K;
  endproperty
  a_fs12: assert property (p_fs12) else $error("base zero not 12 kHz");
  property p_fs;
    @(posedge mclk_i) disable iff (!nrst_i) ctrl_o[1:0] != 2'h0 |-> fs_hz_o ==
      ((ctrl_o[1] ? (ctrl_o[0] ? FS_48K : FS_44K1) : FS_32K) << ctrl_o[4]);
  endproperty
  a_fs: assert property (p_fs) else $error("sample rate decode wrong");
  property p_rst;
    @(posedge mclk_i) disable iff (!nrst_i) $rose(nrst_i) |-> ctrl_o == CTRL_RESET;
  endproperty
  a_rst: assert property (p_rst) else $error("control not at reset value");
endmodule : clk_ctrl_props

bind audio_clock_ctrl_i2c_slave clk_ctrl_props clk_ctrl_props_inst (
  .mclk_i(mclk_i), .nrst_i(nrst_i), .ref_clk_i(ref_clk_i), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .master_clock_en_o(master_clock_en_o),
  .audio_clock_a_en_o(audio_clock_a_en_o), .audio_clock_b_en_o(audio_clock_b_en_o),
  .rate_double_o(rate_double_o), .scale_sel_o(scale_sel_o), .base_rate_o(base_rate_o),
  .scale_factor_o(scale_factor_o), .fs_hz_o(fs_hz_o), .ctrl_o(ctrl_o));

// ==== verification/i2c_master_model.sv ====
// Behavioural two-wire bus master, stepped on the link clock.
// Assumes the bench resolves SDA with a pull-up and feeds it back.
module i2c_master_model (
  input wire logic ref_clk_i, // Link clock
  input wire logic sda_i, // Resolved data line
  output logic scl_o, // Bus clock
  output logic sda_o // Data, 1 = released
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : wt
  // ----------------------------------------
  // Bus conditions
  // ----------------------------------------
  // Phases of 8 cycles leave margin over the slave's input filter
  task automatic start_c();
    sda_o <= 1'b1;
    wt(10);
    scl_o <= 1'b1;
    wt(8);
    sda_o <= 1'b0;
    wt(8);
    scl_o <= 1'b0;
    wt(2);
  endtask : start_c
  task automatic stop_c();
    sda_o <= 1'b0;
    wt(8);
    scl_o <= 1'b1;
    wt(8);
    sda_o <= 1'b1;
    wt(8);
  endtask : stop_c
  task automatic bit_io(input logic b, output logic r);
    sda_o <= b;
    wt(8);
    scl_o <= 1'b1;
    wt(8);
    r = sda_i;
    scl_o <= 1'b0;
    wt(2);
  endtask : bit_io
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
    output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(ack_in, ack);
  endtask : xfer
endmodule : i2c_master_model

// ==== verification/audio_clock_ctrl_i2c_slave_tb.sv ====
// Self-checking bench for the audio clock control slave.
// Drives the bus through the master model; SDA has a pull-up.
module audio_clock_ctrl_i2c_slave_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import clk_ctrl_pkg::*;
  logic mclk_i, nrst_i, ref_clk_i, scl, sda_m, sda_drv, sda_oe, a, mc_en, a_en, b_en, rd;
  logic [1:0] strap_a, strap_b, scl_sel, base;
  logic [9:0] scale;
  logic [16:0] fs;
  logic [7:0] ctrl, q;
  wire logic sda = sda_m & !(sda_oe & !sda_drv);
  int num_errors = 0;
  int n_checks = 0;
  logic [7:0] vals [7] = '{8'h00, 8'h15, 8'h3a, 8'h5f, 8'h9c, 8'hf0, 8'hee};
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  initial begin
    ref_clk_i = 1'b0;
    #7;
    forever #15 ref_clk_i = ~ref_clk_i;
  end
  audio_clock_ctrl_i2c_slave audio_clock_ctrl_i2c_slave_inst (.mclk_i(mclk_i),
    .nrst_i(nrst_i), .ref_clk_i(ref_clk_i), .scl_i(scl), .sda_i(sda),
    .addr_strap_a_i(strap_a), .addr_strap_b_i(strap_b), .sda_o(sda_drv), .sda_oe_o(sda_oe),
    .master_clock_en_o(mc_en), .audio_clock_a_en_o(a_en), .audio_clock_b_en_o(b_en),
    .rate_double_o(rd), .scale_sel_o(scl_sel), .base_rate_o(base),
    .scale_factor_o(scale), .fs_hz_o(fs), .ctrl_o(ctrl));
  i2c_master_model m (.ref_clk_i(ref_clk_i), .sda_i(sda), .scl_o(scl), .sda_o(sda_m));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic report_and_stop();
    if (num_errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  task automatic do_reset(input logic [1:0] sa, input logic [1:0] sb);
    @(posedge mclk_i);
    nrst_i <= 1'b0;
    strap_a <= sa;
    strap_b <= sb;
    repeat (4) @(posedge mclk_i);
    nrst_i <= 1'b1;
    repeat (10) @(posedge mclk_i);
  endtask : do_reset
  task automatic wr(input logic [6:0] ad, input logic [7:0] d, input logic nak);
    m.start_c();
    m.xfer({ad, 1'b0}, 1'b1, q, a);
    check("address ack", a, nak);
    m.xfer(d, 1'b1, q, a);
    check("data ack", a, nak);
    m.stop_c();
  endtask : wr
  function automatic logic [9:0] scale_exp(input logic [7:0] c);
    case (c[3:2])
      2'h0: return SCALE_256;
      2'h1: return SCALE_384;
      2'h2: return SCALE_768;
      default: return SCALE_RSVD;
    endcase
  endfunction : scale_exp
  function automatic logic [16:0] fs_exp(input logic [7:0] c);
    case (c[1:0])
      2'h0: return FS_12K;
      2'h1: return FS_32K << c[4];
      2'h2: return FS_44K1 << c[4];
      default: return FS_48K << c[4];
    endcase
  endfunction : fs_exp
  task automatic chk_out(input logic [7:0] c);
    check("control", ctrl, c);
    check("enables", {mc_en, b_en, a_en}, c[7:5]);
    check("rate fields", {rd, scl_sel, base}, c[4:0]);
    check("scale", scale, scale_exp(c));
    check("sample rate", fs, fs_exp(c));
  endtask : chk_out
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    nrst_i = 1'b0;
    strap_a = STRAP_LOW;
    strap_b = STRAP_LOW;
    do_reset(STRAP_LOW, STRAP_LOW);
    chk_out(8'he1);
    wr(ADDR_OO, 8'h55, 1'b1);
    chk_out(8'he1);
    foreach (vals[i]) begin
      wr(ADDR_LL, vals[i], 1'b0);
      chk_out(vals[i]);
    end
    // Two bytes in one write, last one wins
    m.start_c();
    m.xfer({ADDR_LL, 1'b0}, 1'b1, q, a);
    m.xfer(8'h12, 1'b1, q, a);
    m.xfer(8'ha7, 1'b1, q, a);
    check("second byte ack", a, 1'b0);
    m.stop_c();
    chk_out(8'ha7);
    m.start_c();
    m.xfer({ADDR_LL, 1'b1}, 1'b1, q, a);
    check("read address ack", a, 1'b0);
    m.xfer(8'hff, 1'b0, q, a);
    check("read byte", q, 8'ha7);
    m.xfer(8'hff, 1'b1, q, a);
    check("repeated read byte", q, 8'ha7);
    m.stop_c();
    check("idle data line", sda, 1'b1);
    // Stop after half a data byte must leave the register alone
    m.start_c();
    m.xfer({ADDR_LL, 1'b0}, 1'b1, q, a);
    for (int i = 0; i < 4; i++) begin
      m.bit_io(1'b0, a);
    end
    m.stop_c();
    chk_out(8'ha7);
    // Restart after three data bits: only the new transfer may land
    m.start_c();
    m.xfer({ADDR_LL, 1'b0}, 1'b1, q, a);
    for (int i = 0; i < 3; i++) begin
      m.bit_io(1'b1, a);
    end
    wr(ADDR_LL, 8'h3c, 1'b0);
    chk_out(8'h3c);
    do_reset(STRAP_HIGH, STRAP_HIGH);
    chk_out(8'he1);
    wr(ADDR_LL, 8'h0f, 1'b1);
    wr(ADDR_HH, 8'h0f, 1'b0);
    chk_out(8'h0f);
    report_and_stop();
  end
  initial begin
    #2000000;
    num_errors++;
    report_and_stop();
  end
endmodule : audio_clock_ctrl_i2c_slave_tb
